/* File: verilog/nvm_regs.svh */
// Offsets, field positions, reset values and timing counts of the store
`ifndef NVM_REGS_SVH
`define NVM_REGS_SVH
// ==========================================================
// Register indexes (memory view address is the index plus 0x20)
`define NVM_IDX_STAT 7'h1b
`define NVM_IDX_CTRL 7'h1c
`define NVM_IDX_DATA 7'h1d
`define NVM_IDX_ADDRL 7'h1e
`define NVM_IDX_ADDRH 7'h1f
`define NVM_IO_TOP 7'h3f
`define NVM_BITIO_TOP 7'h1f
`define NVM_MEM_OFS 7'h20
`define NVM_MEM_TOP 7'h5f
// ==========================================================
// Control and status fields
`define NVM_CB_RE 0
`define NVM_CB_PE 1
`define NVM_CB_MPE 2
`define NVM_CB_RIE 3
`define NVM_CB_PM_LO 4
`define NVM_CB_PM_HI 5
`define NVM_SB_DONE 0
`define NVM_SB_BUSY 1
// ==========================================================
// Reset and erased values
`define NVM_ERASED 8'hff
`define NVM_RST_BYTE 8'h00
// ==========================================================
// Timing
`define NVM_MPE_WIN 3'h4
`define NVM_STALL_RD 3'h4
`define NVM_STALL_PROG 3'h2
`define NVM_CLK_MHZ 250
`define NVM_OSC_DIV 250
`define NVM_T_ATOMIC_US 3400
`define NVM_T_SPLIT_US 1800
`endif

/* File: verilog/nvm_pkg.sv */
// Types shared by the store controller
package nvm_pkg;
	typedef enum logic [1:0] {
		NVM_MODE_ATOMIC,
		NVM_MODE_ERASE,
		NVM_MODE_WRITE,
		NVM_MODE_RSVD
	} nvm_mode_t;
	typedef enum logic [1:0] {
		NVM_BIT_NONE,
		NVM_BIT_SET,
		NVM_BIT_CLR
	} nvm_bitop_t;
	typedef enum logic {
		NVM_ST_IDLE,
		NVM_ST_PROG
	} nvm_state_t;
endpackage

/* File: verilog/nvm_prog_timer.sv */
// Program timer clocked by the calibrated oscillator enable
`timescale 1ns/1ns
module nvm_prog_timer #(
	parameter int DIV = 250,
	parameter int TW = 12
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic supplyOk,
	input wire logic start,
	input wire logic [TW-1:0] ticks,
	output logic busy,
	output logic done
);

localparam int DW = $clog2(DIV);

logic [DW-1:0] div_r;
logic oscTick;
logic [TW-1:0] remain_r;

if (DIV < 2) begin : g_chk
	$error("DIV must be at least 2");
end

// ==========================================================
// Oscillator enable, free running
assign oscTick = (div_r == DW'(DIV - 1));

always_ff @(posedge clk_sys) begin
	if (!rst_n || oscTick) begin
		div_r <= '0;
	end else begin
		div_r <= div_r + 1'b1;
	end
end

// ==========================================================
// Countdown; survives a reset while running
assign busy = (remain_r != '0);
assign done = busy && oscTick && (remain_r == TW'(1));

always_ff @(posedge clk_sys) begin
	if (!supplyOk || (!rst_n && !busy)) begin
		remain_r <= '0;
	end else if (start && !busy) begin
		remain_r <= ticks;
	end else if (busy && oscTick) begin
		remain_r <= remain_r - 1'b1;
	end
end

endmodule

/* File: verilog/nvm_ctrl.sv */
// Byte read, erase and program controller for the on-chip data store
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`include "nvm_regs.svh"

module nvm_ctrl
	import nvm_pkg::*;
#(
	parameter int DEPTH = 512,
	parameter int OSC_DIV = `NVM_OSC_DIV,
	parameter int T_ATOMIC_TICKS =
		`NVM_T_ATOMIC_US * `NVM_CLK_MHZ / OSC_DIV,
	parameter int T_SPLIT_TICKS =
		`NVM_T_SPLIT_US * `NVM_CLK_MHZ / OSC_DIV
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic supplyOk,
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [7:0] avs_writedata,
	input wire logic memSpace,
	input wire logic [1:0] bitOp,
	input wire logic [2:0] bitIdx,
	input wire logic globalIrqEn,
	output logic [7:0] avs_readdata,
	output logic avs_waitrequest,
	output logic cpuStall,
	output logic readyIrq
);

localparam int AW = $clog2(DEPTH);
localparam int TW = $clog2(T_ATOMIC_TICKS + 1);

// ==========================================================
// Elaboration checks
if (!(DEPTH == 128 || DEPTH == 256 || DEPTH == 512)) begin : g_chk_d
	$error("DEPTH must be 128, 256 or 512");
end
if (T_SPLIT_TICKS < 1 || T_SPLIT_TICKS > T_ATOMIC_TICKS) begin : g_chk_t
	$error("Program tick counts out of range");
end

logic [7:0] mem [DEPTH];
logic [7:0] addrLo_r;
logic addrHi_r;
logic [7:0] data_r;
nvm_mode_t pmode_r;
logic rie_r;
logic mpe_r;
logic [2:0] mpeCnt_r;
logic pe_r;
nvm_state_t state_r;
logic doneFlag_r;
logic [2:0] holdCnt_r;
logic rdValid_r;
logic [7:0] readData_r;
logic [AW-1:0] opAddr_r;
logic [7:0] opData_r;
nvm_mode_t opMode_r;

logic [6:0] ioIdx;
logic ioValid;
logic bitOk;
logic [7:0] wMask;
logic [7:0] wVal;
logic wrAcc;
logic wrOk;
logic wrCtrl;
logic wrStat;
logic reStrobe;
logic peWrite;
logic mpeWrite;
logic progGo;
logic rdGo;
logic [8:0] addrAll;
logic [AW-1:0] addrIdx;
logic [7:0] rdMux;
logic [TW-1:0] goTicks;
logic tmrBusy;
logic tmrDone;

// ==========================================================
// Address decode, port or memory view
always_comb begin
	ioIdx = avs_address;
	ioValid = (avs_address <= `NVM_IO_TOP);
	if (memSpace) begin
		ioIdx = avs_address - `NVM_MEM_OFS;
		ioValid = (avs_address >= `NVM_MEM_OFS) &&
			(avs_address <= `NVM_MEM_TOP);
	end
end

// Bit operations touch only the named bit of low registers, port view only
assign bitOk = (bitOp == NVM_BIT_NONE) ||
	(!memSpace && ioIdx <= `NVM_BITIO_TOP);

always_comb begin
	wMask = 8'h00;
	wVal = 8'h00;
	case (bitOp)
		NVM_BIT_NONE: begin
			wMask = 8'hff;
			wVal = avs_writedata;
		end
		NVM_BIT_SET: begin
			wMask = 8'h01 << bitIdx;
			wVal = 8'hff;
		end
		NVM_BIT_CLR: begin
			wMask = 8'h01 << bitIdx;
			wVal = 8'h00;
		end
		default: begin
			wMask = 8'h00;
			wVal = 8'h00;
		end
	endcase
end

assign wrAcc = avs_write && (holdCnt_r == 3'h0);
assign wrOk = wrAcc && ioValid && bitOk;
assign wrCtrl = wrOk && (ioIdx == `NVM_IDX_CTRL);
assign wrStat = wrOk && (ioIdx == `NVM_IDX_STAT);
assign reStrobe = wrCtrl && wMask[`NVM_CB_RE] && wVal[`NVM_CB_RE];
assign peWrite = wrCtrl && wMask[`NVM_CB_PE] && wVal[`NVM_CB_PE];
assign mpeWrite = wrCtrl && wMask[`NVM_CB_MPE] && wVal[`NVM_CB_MPE];

// Trigger needs the master enable seen before this write
assign progGo = peWrite && mpe_r && !pe_r &&
	(pmode_r != NVM_MODE_RSVD);
assign rdGo = reStrobe && !pe_r;

assign addrAll = {addrHi_r, addrLo_r} & 9'(DEPTH - 1);
assign addrIdx = addrAll[AW-1:0];

// ==========================================================
// Bus handshake and processor stall
always_ff @(posedge clk_sys) begin
	if (!rst_n) begin
		holdCnt_r <= 3'h0;
	end else if (wrAcc && rdGo) begin
		holdCnt_r <= `NVM_STALL_RD;
	end else if (wrAcc && progGo) begin
		holdCnt_r <= `NVM_STALL_PROG;
	end else if (holdCnt_r != 3'h0) begin
		holdCnt_r <= holdCnt_r - 3'h1;
	end
end

assign cpuStall = (holdCnt_r != 3'h0);
// Reads take one wait cycle so read data comes from a flop
assign avs_waitrequest = (avs_write && cpuStall) ||
	(avs_read && (cpuStall || !rdValid_r));
assign avs_readdata = readData_r;

always_comb begin
	rdMux = 8'h00;
	if (ioValid) begin
		case (ioIdx)
			`NVM_IDX_STAT: rdMux = {6'h00, pe_r, doneFlag_r};
			`NVM_IDX_CTRL: rdMux = {2'b00, pmode_r, rie_r, mpe_r, pe_r, 1'b0};
			`NVM_IDX_DATA: rdMux = data_r;
			`NVM_IDX_ADDRL: rdMux = addrAll[7:0];
			`NVM_IDX_ADDRH: rdMux = {7'h00, addrAll[8]};
			default: rdMux = 8'h00;
		endcase
	end
end

always_ff @(posedge clk_sys) begin
	if (!rst_n) begin
		rdValid_r <= 1'b0;
		readData_r <= `NVM_RST_BYTE;
	end else begin
		rdValid_r <= avs_read && !cpuStall && !rdValid_r;
		if (avs_read && !cpuStall && !rdValid_r) begin
			readData_r <= rdMux;
		end
	end
end

// ==========================================================
// Address and data registers
always_ff @(posedge clk_sys) begin
	if (!rst_n) begin
		addrLo_r <= `NVM_RST_BYTE;
		addrHi_r <= 1'b0;
	end else if (!pe_r) begin
		if (wrOk && ioIdx == `NVM_IDX_ADDRL) begin
			addrLo_r <= (addrLo_r & ~wMask) | (wVal & wMask);
		end
		if (wrOk && ioIdx == `NVM_IDX_ADDRH && wMask[0]) begin
			addrHi_r <= wVal[0];
		end
	end
end

always_ff @(posedge clk_sys) begin
	if (!rst_n) begin
		data_r <= `NVM_RST_BYTE;
	end else if (rdGo) begin
		data_r <= mem[addrIdx];
	end else if (wrOk && ioIdx == `NVM_IDX_DATA) begin
		data_r <= (data_r & ~wMask) | (wVal & wMask);
	end
end

// ==========================================================
// Control fields
always_ff @(posedge clk_sys) begin
	if (!rst_n && (!pe_r || !supplyOk)) begin
		pmode_r <= NVM_MODE_ATOMIC;
	end else if (rst_n && wrCtrl && !pe_r) begin
		pmode_r <= nvm_mode_t'((pmode_r & ~wMask[5:4]) |
			(wVal[5:4] & wMask[5:4]));
	end
end

always_ff @(posedge clk_sys) begin
	if (!rst_n) begin
		rie_r <= 1'b0;
	end else if (wrCtrl && wMask[`NVM_CB_RIE]) begin
		rie_r <= wVal[`NVM_CB_RIE];
	end
end

// Master enable opens a four cycle window
always_ff @(posedge clk_sys) begin
	if (!rst_n) begin
		mpe_r <= 1'b0;
		mpeCnt_r <= 3'h0;
	end else if (mpeWrite) begin
		mpe_r <= 1'b1;
		mpeCnt_r <= `NVM_MPE_WIN;
	end else if (mpeCnt_r == 3'h1) begin
		mpe_r <= 1'b0;
		mpeCnt_r <= 3'h0;
	end else if (mpeCnt_r != 3'h0) begin
		mpeCnt_r <= mpeCnt_r - 3'h1;
	end
end

// Ready level interrupt, no flag of its own
assign readyIrq = rie_r && globalIrqEn && !pe_r;

// ==========================================================
// Program sequencer; a reset does not stop a running operation
always_ff @(posedge clk_sys) begin
	if (!supplyOk) begin
		state_r <= NVM_ST_IDLE;
		pe_r <= 1'b0;
	end else begin
		unique case (state_r)
			NVM_ST_IDLE: begin
				if (rst_n && progGo) begin
					state_r <= NVM_ST_PROG;
					pe_r <= 1'b1;
				end else if (!rst_n) begin
					pe_r <= 1'b0;
				end
			end
			NVM_ST_PROG: begin
				if (tmrDone) begin
					state_r <= NVM_ST_IDLE;
					pe_r <= 1'b0;
				end
			end
		endcase
	end
end

always_ff @(posedge clk_sys) begin
	if (rst_n && progGo) begin
		opAddr_r <= addrIdx;
		opData_r <= data_r;
		opMode_r <= pmode_r;
	end
end

assign goTicks = (pmode_r == NVM_MODE_ATOMIC) ?
	TW'(T_ATOMIC_TICKS) : TW'(T_SPLIT_TICKS);

nvm_prog_timer #(
	.DIV(OSC_DIV),
	.TW(TW)
) u_timer (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.supplyOk(supplyOk),
	.start(rst_n && progGo),
	.ticks(goTicks),
	.busy(tmrBusy),
	.done(tmrDone)
);

// Cells commit at the end of the program time
always_ff @(posedge clk_sys) begin
	if (tmrDone && state_r == NVM_ST_PROG) begin
		unique case (opMode_r)
			NVM_MODE_ATOMIC: mem[opAddr_r] <= opData_r;
			NVM_MODE_ERASE: mem[opAddr_r] <= `NVM_ERASED;
			// Programming only clears bits, so unerased data is lost
			NVM_MODE_WRITE: mem[opAddr_r] <= mem[opAddr_r] & opData_r;
			NVM_MODE_RSVD: mem[opAddr_r] <= mem[opAddr_r];
		endcase
	end
end

// Completion flag, write one to clear, set wins
always_ff @(posedge clk_sys) begin
	if (!rst_n) begin
		doneFlag_r <= 1'b0;
	end else if (tmrDone) begin
		doneFlag_r <= 1'b1;
	end else if (wrStat && wMask[`NVM_SB_DONE] && wVal[`NVM_SB_DONE]) begin
		doneFlag_r <= 1'b0;
	end
end

// ==========================================================
// Assertions
a_read_stall: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(wrAcc && rdGo) |=> cpuStall [*4] ##1 !cpuStall)
	else $error("read stall not four cycles");

a_prog_stall: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(wrAcc && progGo) |=> cpuStall [*2] ##1 !cpuStall)
	else $error("program stall not two cycles");

a_mpe_timeout: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(mpeWrite ##1 (!mpeWrite) [*4]) |=> !mpe_r)
	else $error("master enable not cleared after four cycles");

a_go_needs_mpe: assert property (@(posedge clk_sys) disable iff (!rst_n)
	$rose(pe_r) |-> $past(mpe_r) && $past(peWrite))
	else $error("program started without master enable");

a_pe_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(pe_r && !tmrDone) |=> pe_r)
	else $error("program enable dropped early");

a_pe_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(pe_r && tmrDone) |=> !pe_r && doneFlag_r)
	else $error("program enable not cleared at completion");

a_mode_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
	pe_r |=> $stable(pmode_r))
	else $error("mode changed while busy");

a_busy_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(pe_r && reStrobe) |=> $stable(data_r) && $stable(addrLo_r))
	else $error("read or address change while busy");

a_rsvd_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(peWrite && mpe_r && !pe_r && pmode_r == NVM_MODE_RSVD) |=> !pe_r)
	else $error("reserved mode started an operation");

a_erase_val: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(tmrDone && opMode_r == NVM_MODE_ERASE) |=> mem[opAddr_r] == 8'hff)
	else $error("erase did not leave erased byte");

a_busy_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
	$rose(pe_r) |-> !readyIrq [*1] ##1 (pe_r && !readyIrq))
	else $error("ready interrupt while busy");

a_timer_busy: assert property (@(posedge clk_sys)
	disable iff (!supplyOk) pe_r == tmrBusy)
	else $error("program enable and timer disagree");

endmodule

/* File: verif/nvm_cpu_model.sv */
// Processor-core model issuing register accesses over Avalon-MM
`timescale 1ns/1ns
module nvm_cpu_model (
	input wire logic clk_sys,
	input wire logic avs_waitrequest,
	input wire logic [7:0] avs_readdata,
	output logic [6:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [7:0] avs_writedata,
	output logic memSpace,
	output logic [1:0] bitOp,
	output logic [2:0] bitIdx
);
	initial begin
		avs_address = 7'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 8'h00;
		memSpace = 1'b0;
		bitOp = 2'h3;
		bitIdx = 3'h0;
	end
	// ==========================
	// Bus cycle
	task automatic xfer(input logic rd, input logic ms,
		input logic [1:0] op, input logic [2:0] b,
		input logic [6:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_sys);
		avs_address <= ms ? idx + 7'h20 : idx;
		memSpace <= ms;
		bitOp <= op;
		bitIdx <= b;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		// Request stands until waitrequest is sampled low at a rising edge
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		bitOp <= 2'h3;
		// Idle address and data lines show the inverse, never a stale value; memSpace and bitIdx keep their last value
		avs_address <= ~avs_address;
		avs_writedata <= ~d;
	endtask
endmodule

/* File: verif/nvm_ctrl_tb.sv */
// Self-checking bench for the byte store controller
`timescale 1ns/1ns
`include "nvm_regs.svh"
module nvm_ctrl_tb
	import nvm_pkg::*;
;
	localparam int DIV = 4;
	localparam int TA = 20;
	localparam int TS = 10;
	logic clk_sys, rst_n, supplyOk, globalIrqEn;
	logic [6:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest, memSpace;
	logic [7:0] avs_writedata, avs_readdata, q;
	logic [1:0] bitOp;
	logic [2:0] bitIdx;
	logic cpuStall, readyIrq;
	int errors = 0;
	int n_checks = 0;
	int i;
	nvm_ctrl #(.DEPTH(512), .OSC_DIV(DIV), .T_ATOMIC_TICKS(TA),
		.T_SPLIT_TICKS(TS)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
		.supplyOk(supplyOk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .memSpace(memSpace),
		.bitOp(bitOp), .bitIdx(bitIdx), .globalIrqEn(globalIrqEn),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cpuStall(cpuStall), .readyIrq(readyIrq));
	nvm_cpu_model cpu (.clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .memSpace(memSpace),
		.bitOp(bitOp), .bitIdx(bitIdx));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// ==========================
	// Helpers
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		cpu.xfer(1'b0, 1'b0, 2'h0, 3'h0, a, d, r);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		cpu.xfer(1'b1, 1'b0, 2'h0, 3'h0, a, 8'h00, r);
		chk(r, e);
	endtask
	task automatic setup(input nvm_mode_t m, input logic [7:0] d);
		wr(`NVM_IDX_CTRL, {2'h0, m, 4'h8});
		wr(`NVM_IDX_ADDRH, 8'h01);
		wr(`NVM_IDX_ADDRL, 8'h23);
		wr(`NVM_IDX_DATA, d);
		wr(`NVM_IDX_CTRL, {2'h0, m, 4'hc});
	endtask
	// Zero ticks means the trigger must be refused
	task automatic fire(input nvm_mode_t m, input int t);
		int s;
		int n;
		s = 0;
		wr(`NVM_IDX_CTRL, {2'h0, m, 4'ha});
		for (n = 1; n < 2000; n++) begin
			@(negedge clk_sys);
			if (cpuStall === 1'b1)
				s++;
			if (readyIrq === 1'b1)
				break;
		end
		chk(8'(s), (t != 0) ? 8'h02 : 8'h00);
		if (t == 0)
			chk(8'(n), 8'h01);
		else
			chk({7'h00, n >= t*DIV-DIV+2 && n <= t*DIV+1}, 8'h01);
	endtask
	task automatic rdmem(input logic [7:0] e);
		int s;
		s = 0;
		wr(`NVM_IDX_CTRL, 8'h09);
		repeat (6) begin
			@(negedge clk_sys);
			if (cpuStall === 1'b1)
				s++;
		end
		chk(8'(s), 8'h04);
		rdc(`NVM_IDX_DATA, e);
	endtask
	task automatic pulse_rst();
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		close_out();
	end
	// ==========================
	// Tests
	initial begin
		rst_n = 1'b0;
		supplyOk = 1'b0;
		globalIrqEn = 1'b0;
		repeat (8) @(posedge clk_sys);
		supplyOk <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		globalIrqEn <= 1'b1;
		rdc(`NVM_IDX_CTRL, 8'h00);
		rdc(`NVM_IDX_STAT, 8'h00);
		rdc(`NVM_IDX_DATA, 8'h00);
		$display("reset values done");
		wr(`NVM_IDX_ADDRL, 8'h23);
		cpu.xfer(1'b0, 1'b0, 2'h1, 3'h7, `NVM_IDX_ADDRL, 8'h00, q);
		cpu.xfer(1'b0, 1'b0, 2'h2, 3'h0, `NVM_IDX_ADDRL, 8'hff, q);
		rdc(`NVM_IDX_ADDRL, 8'ha2);
		cpu.xfer(1'b0, 1'b1, 2'h1, 3'h6, `NVM_IDX_ADDRL, 8'h00, q);
		cpu.xfer(1'b1, 1'b1, 2'h0, 3'h0, `NVM_IDX_ADDRL, 8'h00, q);
		chk(q, 8'ha2);
		wr(7'h05, 8'hff);
		rdc(7'h05, 8'h00);
		$display("register access done");
		setup(NVM_MODE_ATOMIC, 8'ha5);
		fire(NVM_MODE_ATOMIC, TA);
		rdc(`NVM_IDX_STAT, 8'h01);
		wr(`NVM_IDX_STAT, 8'h01);
		rdc(`NVM_IDX_STAT, 8'h00);
		rdmem(8'ha5);
		chk({7'h00, readyIrq}, 8'h01);
		@(posedge clk_sys);
		globalIrqEn <= 1'b0;
		@(negedge clk_sys);
		chk({7'h00, readyIrq}, 8'h00);
		@(posedge clk_sys);
		globalIrqEn <= 1'b1;
		$display("atomic done");
		setup(NVM_MODE_ERASE, 8'h00);
		fire(NVM_MODE_ERASE, TS);
		rdmem(8'hff);
		// Erased first, so write-only data is kept
		setup(NVM_MODE_WRITE, 8'h3c);
		fire(NVM_MODE_WRITE, TS);
		rdmem(8'h3c);
		$display("split modes done");
		setup(NVM_MODE_ATOMIC, 8'h11);
		rdc(`NVM_IDX_CTRL, 8'h0c);
		repeat (8) @(posedge clk_sys);
		rdc(`NVM_IDX_CTRL, 8'h08);
		fire(NVM_MODE_ATOMIC, 0);
		setup(NVM_MODE_RSVD, 8'h22);
		fire(NVM_MODE_RSVD, 0);
		rdmem(8'h3c);
		$display("refused triggers done");
		setup(NVM_MODE_ATOMIC, 8'h5a);
		wr(`NVM_IDX_CTRL, 8'h0a);
		repeat (4) @(posedge clk_sys);
		rdc(`NVM_IDX_CTRL, 8'h0a);
		rdc(`NVM_IDX_STAT, 8'h03);
		wr(`NVM_IDX_ADDRL, 8'h00);
		wr(`NVM_IDX_CTRL, 8'h19);
		rdc(`NVM_IDX_ADDRL, 8'h23);
		rdc(`NVM_IDX_DATA, 8'h5a);
		rdc(`NVM_IDX_CTRL, 8'h0a);
		chk({7'h00, readyIrq}, 8'h00);
		pulse_rst();
		rdc(`NVM_IDX_STAT, 8'h02);
		for (i = 0; i < 200; i++) begin
			cpu.xfer(1'b1, 1'b0, 2'h0, 3'h0, `NVM_IDX_STAT, 8'h00, q);
			if (q[`NVM_SB_BUSY] === 1'b0)
				break;
		end
		chk(q, 8'h01);
		// Reset cleared the address; the running write kept its own copy
		wr(`NVM_IDX_ADDRH, 8'h01);
		wr(`NVM_IDX_ADDRL, 8'h23);
		rdmem(8'h5a);
		wr(`NVM_IDX_CTRL, 8'h10);
		pulse_rst();
		rdc(`NVM_IDX_CTRL, 8'h00);
		chk({7'h00, cpuStall}, 8'h00);
		$display("busy and reset done");
		close_out();
	end
endmodule
